/* hdl/pes_regs.svh */
// register offsets, field positions, reset values and timing counts of the protection supervisor
`ifndef PES_REGS_SVH
`define PES_REGS_SVH
`define PES_CTRL_OFS 12'h000
`define PES_RESP_OFS 12'h004
`define PES_PDT_DLY_OFS 12'h008
`define PES_WDG_DLY_OFS 12'h00c
`define PES_WDG_START_OFS 12'h010
`define PES_LIM_CFG_OFS 12'h014
`define PES_STATUS_OFS 12'h018
`define PES_IRQ_STAT_OFS 12'h01c
`define PES_IRQ_MASK_OFS 12'h020
`define PES_ACK_OFS 12'h024
`define PES_RESP_PDT_LSB 0
`define PES_RESP_WDG_LSB 4
`define PES_RESP_OPI_LSB 8
`define PES_RESP_MFAN_LSB 12
`define PES_RESP_IFAN_LSB 16
`define PES_LIM_SEL_LSB 0
`define PES_LIM_TYPE_LSB 2
`define PES_LIM_EN_LSB 4
`define PES_LIM_THR_LSB 16
`define PES_CTRL_OPI_HOLD_BIT 0
`define PES_CTRL_BRK_OWN_BIT 1
`define PES_CTRL_RUN_BIT 2
`define PES_RESP_RST 32'h0000_0000
`define PES_DLY_RST 16'h000a
`define PES_OPI_LOSS_MS 5000
`define PES_TICK_NS 1000000
`define PES_CLK_NS 10
`define PES_TICK_CYC (`PES_TICK_NS / `PES_CLK_NS)
`endif

/* hdl/pes_pkg.sv */
// types of the protection supervisor
package pes_pkg;
    typedef enum logic [3:0] {
        PES_R_IGNORE = 4'h0,
        PES_R_INFO = 4'h1,
        PES_R_INFO2 = 4'h2,
        PES_R_WARN = 4'h3,
        PES_R_WARN_HOLD = 4'h4,
        PES_R_FAULT = 4'ha,
        PES_R_FAULT_BRK = 4'hb,
        PES_R_WARN_RAMP = 4'hd
    } pes_resp_t;
    typedef struct packed {
        logic log;
        logic warn;
        logic ramp;
        logic fault;
        logic brk;
    } pes_act_t;
    typedef struct packed {
        logic [1:0] sel;
        logic [1:0] kind;
        logic [1:0] en;
        logic [15:0] thr;
    } pes_lim_t;
    typedef struct packed {
        logic [15:0] dc_cur;
        logic [15:0] dc_pwr;
        logic [15:0] grid_cur;
        logic [15:0] grid_pwr;
    } pes_meas_t;
endpackage

/* hdl/pes_supervisor.sv */
// protection event supervisor with ahb-lite register slave
`timescale 1ns/100ps
`include "pes_regs.svh"
module pes_supervisor #(
    parameter int TICK_CYC = `PES_TICK_CYC,
    parameter int OPI_LOSS_TICKS = `PES_OPI_LOSS_MS
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic pd_update,
    input wire logic wdg_trip,
    input wire logic opi_alive,
    input wire logic main_fan_fail,
    input wire logic int_fan_fail,
    input wire logic wake,
    input wire pes_pkg::pes_meas_t meas,
    output logic irq,
    output logic warning,
    output logic fault,
    output logic modulation_stop,
    output logic main_breaker_open,
    output logic current_limit_ramp,
    output logic dc_link_discharge,
    output logic release_control,
    output logic log_event
);
    import pes_pkg::*;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // illegal codes for a given event map to ignore
    function automatic pes_act_t decode(input logic [3:0] c, input logic ramp_ok,
                                        input logic opi, input logic own);
        pes_act_t a;
        a = '0;
        unique case (c)
            PES_R_INFO: a.log = !opi;
            PES_R_INFO2: a.log = opi;
            PES_R_WARN: a.warn = !opi;
            PES_R_WARN_HOLD: a.warn = opi;
            PES_R_WARN_RAMP: begin
                a.warn = ramp_ok;
                a.ramp = ramp_ok;
            end
            PES_R_FAULT: a.fault = 1'b1;
            PES_R_FAULT_BRK: begin
                a.fault = 1'b1;
                a.brk = own;
            end
            default: a = '0;
        endcase
        return a;
    endfunction

    function automatic logic [15:0] dly_inc(input logic [15:0] v, input logic tk);
        return (tk && v != 16'hffff) ? v + 16'h0001 : v;
    endfunction

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [5:0] s1_r, s2_r, s3_r;
    logic [5:0] pins;
    assign pins = {wake, int_fan_fail, main_fan_fail, opi_alive, wdg_trip, pd_update};
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1_r <= 6'h00;
            s2_r <= 6'h00;
            s3_r <= 6'h00;
        end else begin
            s1_r <= pins;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end
    logic pd_edge, opi_edge;
    assign pd_edge = s2_r[0] && !s3_r[0];
    assign opi_edge = s2_r[2] != s3_r[2];

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [31:0] ctrl_r, ctrl_nxt, resp_r, resp_nxt, lim_r, lim_nxt;
    logic [15:0] pdt_dly_r, pdt_dly_nxt, wdg_dly_r, wdg_dly_nxt, wst_r, wst_nxt;
    logic [4:0] ist_r, ist_nxt, imask_r, imask_nxt;
    logic ack_pulse;
    logic [11:0] a_ofs_r;
    logic a_wr_r, a_rd_r;
    logic [31:0] rdata_nxt;
    logic hready_r;
    logic [4:0] ev_set;
    logic [15:0] status_w;
    pes_lim_t lim;
    assign lim = pes_lim_t'({lim_r[1:0], lim_r[3:2], lim_r[5:4], lim_r[31:16]});

    always_comb begin
        ctrl_nxt = ctrl_r;
        resp_nxt = resp_r;
        lim_nxt = lim_r;
        pdt_dly_nxt = pdt_dly_r;
        wdg_dly_nxt = wdg_dly_r;
        wst_nxt = wst_r;
        imask_nxt = imask_r;
        ack_pulse = 1'b0;
        // set wins over write-one clear
        ist_nxt = ist_r;
        if (a_wr_r && a_ofs_r == `PES_IRQ_STAT_OFS) begin
            ist_nxt = ist_r & ~hwdata[4:0];
        end
        ist_nxt = ist_nxt | ev_set;
        if (a_wr_r) begin
            unique case (a_ofs_r)
                `PES_CTRL_OFS: ctrl_nxt = {29'h0, hwdata[2:0]};
                `PES_RESP_OFS: resp_nxt = {12'h0, hwdata[19:0]};
                `PES_PDT_DLY_OFS: pdt_dly_nxt = hwdata[15:0];
                `PES_WDG_DLY_OFS: wdg_dly_nxt = hwdata[15:0];
                `PES_WDG_START_OFS: wst_nxt = hwdata[15:0];
                `PES_LIM_CFG_OFS: lim_nxt = {hwdata[31:16], 10'h0, hwdata[5:0]};
                `PES_IRQ_MASK_OFS: imask_nxt = hwdata[4:0];
                `PES_ACK_OFS: ack_pulse = hwdata[0];
                default: ;
            endcase
        end
        rdata_nxt = 32'h0000_0000;
        if (a_rd_r) begin
            unique case (a_ofs_r)
                `PES_CTRL_OFS: rdata_nxt = ctrl_r;
                `PES_RESP_OFS: rdata_nxt = resp_r;
                `PES_PDT_DLY_OFS: rdata_nxt = {16'h0, pdt_dly_r};
                `PES_WDG_DLY_OFS: rdata_nxt = {16'h0, wdg_dly_r};
                `PES_WDG_START_OFS: rdata_nxt = {16'h0, wst_r};
                `PES_LIM_CFG_OFS: rdata_nxt = lim_r;
                `PES_STATUS_OFS: rdata_nxt = {16'h0, status_w};
                `PES_IRQ_STAT_OFS: rdata_nxt = {27'h0, ist_r};
                `PES_IRQ_MASK_OFS: rdata_nxt = {27'h0, imask_r};
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            a_ofs_r <= 12'h000;
            a_wr_r <= 1'b0;
            a_rd_r <= 1'b0;
            ctrl_r <= 32'h0000_0000;
            resp_r <= `PES_RESP_RST;
            lim_r <= 32'h0000_0000;
            pdt_dly_r <= `PES_DLY_RST;
            wdg_dly_r <= `PES_DLY_RST;
            wst_r <= `PES_DLY_RST;
            ist_r <= 5'h00;
            imask_r <= 5'h00;
            hrdata <= 32'h0000_0000;
            hready_r <= 1'b1;
        end else begin
            a_ofs_r <= haddr[11:0];
            a_wr_r <= hsel && hready && htrans[1] && hwrite;
            a_rd_r <= hsel && hready && htrans[1] && !hwrite;
            ctrl_r <= ctrl_nxt;
            resp_r <= resp_nxt;
            lim_r <= lim_nxt;
            pdt_dly_r <= pdt_dly_nxt;
            wdg_dly_r <= wdg_dly_nxt;
            wst_r <= wst_nxt;
            ist_r <= ist_nxt;
            imask_r <= imask_nxt;
            hrdata <= rdata_nxt;
            // one wait state on reads only
            hready_r <= !(hsel && hready && htrans[1] && !hwrite);
        end
    end
    // reads decode after a preceding write has landed, so no stale data
    assign hreadyout = hready_r;
    assign hresp = 1'b0;

    // ----------------------------------------
    // time base and delay counters
    // ----------------------------------------
    logic [31:0] tdiv_r, tdiv_nxt;
    logic tick;
    logic [15:0] pdt_cnt_r, pdt_cnt_nxt, wdg_cnt_r, wdg_cnt_nxt, st_cnt_r, st_cnt_nxt;
    logic [15:0] opi_cnt_r, opi_cnt_nxt;
    logic awake_r, awake_nxt;
    assign tick = tdiv_r == 32'(TICK_CYC - 1);

    always_comb begin
        tdiv_nxt = tick ? 32'h0 : tdiv_r + 32'h1;
        pdt_cnt_nxt = pd_edge ? 16'h0 : dly_inc(pdt_cnt_r, tick);
        wdg_cnt_nxt = s2_r[1] ? dly_inc(wdg_cnt_r, tick) : 16'h0;
        awake_nxt = awake_r || s2_r[5];
        st_cnt_nxt = awake_r ? dly_inc(st_cnt_r, tick) : 16'h0;
        opi_cnt_nxt = (opi_edge || !ctrl_r[`PES_CTRL_OPI_HOLD_BIT]) ? 16'h0
                      : dly_inc(opi_cnt_r, tick);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tdiv_r <= 32'h0;
            pdt_cnt_r <= 16'h0;
            wdg_cnt_r <= 16'h0;
            st_cnt_r <= 16'h0;
            opi_cnt_r <= 16'h0;
            awake_r <= 1'b0;
        end else begin
            tdiv_r <= tdiv_nxt;
            pdt_cnt_r <= pdt_cnt_nxt;
            wdg_cnt_r <= wdg_cnt_nxt;
            st_cnt_r <= st_cnt_nxt;
            opi_cnt_r <= opi_cnt_nxt;
            awake_r <= awake_nxt;
        end
    end

    // ----------------------------------------
    // event detection and limit supervision
    // ----------------------------------------
    logic ev_pdt, ev_wdg, ev_opi, ev_mfan, ev_ifan, lim_act;
    logic [15:0] sup_val;
    logic lim_gate, lim_beyond;
    logic run, own, ramp_r, ramp_nxt;
    assign run = ctrl_r[`PES_CTRL_RUN_BIT];
    assign own = ctrl_r[`PES_CTRL_BRK_OWN_BIT];
    assign ev_pdt = pdt_cnt_r >= pdt_dly_r;
    assign ev_wdg = wdg_cnt_r >= wdg_dly_r && st_cnt_r >= wst_r;
    assign ev_opi = ctrl_r[`PES_CTRL_OPI_HOLD_BIT]
                    && opi_cnt_r >= 16'(OPI_LOSS_TICKS);
    assign ev_mfan = s2_r[3];
    assign ev_ifan = s2_r[4];

    always_comb begin
        unique case (lim.sel)
            2'd0: sup_val = meas.dc_cur;
            2'd1: sup_val = meas.dc_pwr;
            2'd2: sup_val = meas.grid_cur;
            default: sup_val = meas.grid_pwr;
        endcase
        unique case (lim.en)
            2'd0: lim_gate = 1'b0;
            2'd1: lim_gate = 1'b1;
            2'd2: lim_gate = ramp_r;
            default: lim_gate = run;
        endcase
        unique case (lim.kind)
            2'd1: lim_beyond = $signed(sup_val) < $signed(lim.thr);
            2'd2: lim_beyond = $signed(sup_val) > $signed(lim.thr);
            default: lim_beyond = 1'b0;
        endcase
    end
    assign lim_act = lim_gate && lim_beyond;

    // ----------------------------------------
    // response decoding and latched actions
    // ----------------------------------------
    pes_act_t a_pdt, a_wdg, a_opi, a_mf, a_if, act_all;
    logic [4:0] ev_now, ev_prev_r;
    logic hold_warn_r, hold_warn_nxt, lim_flt_r;
    assign a_pdt = ev_pdt ? decode(resp_r[3:0], 1'b1, 1'b0, own) : '0;
    assign a_wdg = ev_wdg ? decode(resp_r[7:4], 1'b1, 1'b0, own) : '0;
    assign a_opi = ev_opi ? decode(resp_r[11:8], 1'b0, 1'b1, own) : '0;
    assign a_mf = ev_mfan ? decode(resp_r[15:12], 1'b0, 1'b0, own) : '0;
    assign a_if = ev_ifan ? decode(resp_r[19:16], 1'b0, 1'b0, own) : '0;
    assign act_all = a_pdt | a_wdg | a_opi | a_mf | a_if;
    assign ev_now = {ev_ifan, ev_mfan, ev_opi, ev_wdg, ev_pdt};
    assign ev_set = ev_now & ~ev_prev_r;
    assign status_w = {8'h0, lim_flt_r, ramp_r, hold_warn_r, ev_now};

    always_comb begin
        // ramp and held warning persist until acknowledge
        ramp_nxt = act_all.ramp || (ramp_r && !ack_pulse);
        hold_warn_nxt = a_opi.warn || (hold_warn_r && !ack_pulse);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ev_prev_r <= 5'h00;
            ramp_r <= 1'b0;
            hold_warn_r <= 1'b0;
            lim_flt_r <= 1'b0;
            irq <= 1'b0;
            warning <= 1'b0;
            fault <= 1'b0;
            modulation_stop <= 1'b0;
            main_breaker_open <= 1'b0;
            current_limit_ramp <= 1'b0;
            dc_link_discharge <= 1'b0;
            release_control <= 1'b0;
            log_event <= 1'b0;
        end else begin
            ev_prev_r <= ev_now;
            ramp_r <= ramp_nxt;
            hold_warn_r <= hold_warn_nxt;
            lim_flt_r <= lim_act;
            irq <= |(ist_nxt & imask_r);
            warning <= act_all.warn || hold_warn_nxt || ramp_nxt;
            fault <= act_all.fault || lim_act;
            modulation_stop <= act_all.fault || (lim_act && run);
            main_breaker_open <= act_all.brk || (lim_act && own);
            current_limit_ramp <= ramp_nxt;
            dc_link_discharge <= lim_act;
            release_control <= ev_opi;
            log_event <= |(ev_set & {a_if.log, a_mf.log, a_opi.log, a_wdg.log, a_pdt.log});
        end
    end
endmodule

/* dv/pes_sup_properties.sv */
// port assertions of the protection event supervisor
`timescale 1ns/100ps
`include "pes_regs.svh"
module pes_sup_properties #(
    parameter int TICK_CYC = 4,
    parameter int OPI_LOSS_TICKS = 5
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic opi_alive,
    input wire logic warning,
    input wire logic fault,
    input wire logic modulation_stop,
    input wire logic main_breaker_open,
    input wire logic current_limit_ramp,
    input wire logic dc_link_discharge,
    input wire logic release_control,
    input wire logic log_event
);
    // ----
    // helper state
    // ----
    int quiet_r, quiet_nxt;
    logic opi_q_r, ack_ph_r, ack_ph_nxt;
    logic [3:0] ack_win_r, ack_win_nxt;
    always_comb begin
        // saturates so a long silence never wraps
        quiet_nxt = (opi_alive != opi_q_r) ? 0 : quiet_r + int'(quiet_r < 4096);
        ack_ph_nxt = hsel & hready & htrans[1] & hwrite & (haddr[11:0] == `PES_ACK_OFS);
        ack_win_nxt = {ack_win_r[2:0], ack_ph_r & hwdata[0]};
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            quiet_r <= 0;
            opi_q_r <= 1'b0;
            ack_ph_r <= 1'b0;
            ack_win_r <= 4'h0;
        end else begin
            quiet_r <= quiet_nxt;
            opi_q_r <= opi_alive;
            ack_ph_r <= ack_ph_nxt;
            ack_win_r <= ack_win_nxt;
        end
    end
    // ----
    // properties
    // ----
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    property p_mod_fault;
        modulation_stop |-> fault;
    endproperty
    a_mod_fault: assert property (p_mod_fault)
        else $error("modulation stop without fault");
    property p_brk_fault;
        main_breaker_open |-> fault;
    endproperty
    a_brk_fault: assert property (p_brk_fault)
        else $error("breaker open without fault");
    property p_dis_fault;
        dc_link_discharge |-> fault;
    endproperty
    a_dis_fault: assert property (p_dis_fault)
        else $error("discharge without fault");
    property p_log_pulse;
        log_event |=> !log_event;
    endproperty
    a_log_pulse: assert property (p_log_pulse)
        else $error("log pulse too long");
    property p_ramp_warn;
        $rose(current_limit_ramp) |-> warning;
    endproperty
    a_ramp_warn: assert property (p_ramp_warn)
        else $error("ramp without warning");
    property p_ramp_hold;
        $fell(current_limit_ramp) |-> ack_win_r != 4'h0;
    endproperty
    a_ramp_hold: assert property (p_ramp_hold)
        else $error("ramp dropped without acknowledge");
    property p_opi_quiet;
        $rose(release_control) |-> quiet_r >= (OPI_LOSS_TICKS - 1) * TICK_CYC;
    endproperty
    a_opi_quiet: assert property (p_opi_quiet)
        else $error("control released too early");
    property p_opi_back;
        release_control && (opi_alive != opi_q_r) |-> ##[1:8] !release_control;
    endproperty
    a_opi_back: assert property (p_opi_back)
        else $error("release kept after traffic returned");
endmodule

bind pes_supervisor pes_sup_properties #(
    .TICK_CYC(TICK_CYC),
    .OPI_LOSS_TICKS(OPI_LOSS_TICKS)
) u_props (
    .clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .opi_alive,
    .warning, .fault, .modulation_stop, .main_breaker_open, .current_limit_ramp,
    .dc_link_discharge, .release_control, .log_event
);

/* dv/pes_field_model.sv */
// fieldbus master and operator tool model: process data and link activity pins
`timescale 1ns/100ps
module pes_field_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic pd_on,
    input wire logic opi_on,
    input wire logic [3:0] per,
    output logic pd_update,
    output logic opi_alive
);
    logic [3:0] cnt_r;
    // a silent source simply holds its pin, as a real master would
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= 4'h0;
            pd_update <= 1'b0;
            opi_alive <= 1'b0;
        end else begin
            cnt_r <= (cnt_r >= per) ? 4'h0 : cnt_r + 4'h1;
            if (cnt_r >= per && pd_on) pd_update <= !pd_update;
            if (cnt_r >= per && opi_on) opi_alive <= !opi_alive;
        end
    end
endmodule

/* dv/tb.sv */
// self-checking bench of the protection event supervisor
`timescale 1ns/100ps
`include "pes_regs.svh"
module tb;
    import pes_pkg::*;
    logic clk, resetn, hsel, hwrite, hready, hreadyout, hresp, irq, wdg_trip, wake;
    logic [31:0] haddr, hwdata, hrdata, v;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] per;
    logic [6:0] outs;
    logic [15:0] thr, val;
    logic pd_update, opi_alive, main_fan_fail, int_fan_fail, pd_on, opi_on, log_event;
    logic warning, fault, modulation_stop, main_breaker_open, current_limit_ramp;
    logic dc_link_discharge, release_control;
    pes_meas_t meas;
    int bad_count, tests_run, seed, logs;
    logic [3:0] ev_c [11] = '{4'h0, 4'h1, 4'h3, 4'hd, 4'ha, 4'hb, 4'h0, 4'h2, 4'h4, 4'ha, 4'hb};
    // sel, enable, type, offset (1 above, 2 below), run, expected outputs
    logic [15:0] lim [10] = '{{2'd0, 2'd1, 2'd2, 2'd1, 1'b1, 7'h3a},
        {2'd3, 2'd1, 2'd2, 2'd0, 1'b1, 7'h00}, {2'd1, 2'd1, 2'd1, 2'd2, 1'b1, 7'h3a},
        {2'd2, 2'd1, 2'd1, 2'd0, 1'b1, 7'h00}, {2'd0, 2'd0, 2'd2, 2'd1, 1'b1, 7'h00},
        {2'd1, 2'd1, 2'd0, 2'd1, 1'b1, 7'h00}, {2'd2, 2'd3, 2'd2, 2'd1, 1'b0, 7'h00},
        {2'd2, 2'd1, 2'd2, 2'd1, 1'b0, 7'h2a}, {2'd3, 2'd2, 2'd2, 2'd1, 1'b1, 7'h00},
        {2'd3, 2'd3, 2'd2, 2'd1, 1'b1, 7'h3a}};
    assign outs = {warning, fault, modulation_stop, main_breaker_open, current_limit_ramp,
        dc_link_discharge, release_control};
    // single slave: its ready is the bus ready
    assign hready = hreadyout;
    pes_supervisor #(.TICK_CYC(4), .OPI_LOSS_TICKS(5)) dut (.clk, .resetn, .hsel, .haddr,
        .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .pd_update,
        .wdg_trip, .opi_alive, .main_fan_fail, .int_fan_fail, .wake, .meas, .irq, .warning,
        .fault, .modulation_stop, .main_breaker_open, .current_limit_ramp,
        .dc_link_discharge, .release_control, .log_event);
    pes_field_model model (.clk, .resetn, .pd_on, .opi_on, .per, .pd_update, .opi_alive);
    // ----
    // tasks
    // ----
    task automatic stop_test;
        if (bad_count == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {20'h0, a};
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        v = hrdata;
    endtask
    function automatic logic [6:0] exp_o(input logic [3:0] c, input logic opi);
        logic f;
        f = c == 4'ha || c == 4'hb;
        return {c == 4'h3 || c == 4'hd || c == 4'h4, f, f, c == 4'hb, c == 4'hd, 1'b0, opi};
    endfunction
    task automatic ev_run(input int i);
        logic [3:0] c;
        logic opi;
        int l0;
        c = ev_c[i];
        opi = i > 5;
        bus(1, `PES_RESP_OFS, opi ? {20'h0, c, 8'h0} : {28'h0, c});
        per <= 4'(1 + {$random(seed)} % 2);
        l0 = logs;
        cyc(40);
        chk(32'(outs), 0);
        if (opi) opi_on <= 1'b0;
        else pd_on <= 1'b0;
        cyc(40);
        chk(32'(outs), 32'(exp_o(c, opi)));
        chk(32'(logs - l0), 32'(c == 4'h1 || c == 4'h2));
        pd_on <= 1'b1;
        opi_on <= 1'b1;
        cyc(20);
        chk(32'({current_limit_ramp, warning & opi}), 32'({c == 4'hd, c == 4'h4}));
        bus(1, `PES_ACK_OFS, 32'h1);
        cyc(4);
        chk(32'(outs), 0);
    endtask
    always @(posedge clk) if (log_event === 1'b1) logs <= logs + 1;
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        stop_test();
    end
    // ----
    // main sequence
    // ----
    initial begin
        {resetn, hsel, hwrite, wdg_trip, wake, main_fan_fail, int_fan_fail} = '0;
        {haddr, hwdata, htrans, meas, bad_count, tests_run, logs} = '0;
        {pd_on, opi_on, hsize, per, seed} = {2'b11, 3'h2, 4'h1, 32'd96860};
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        bus(0, `PES_PDT_DLY_OFS, 0);
        chk(v, {16'h0, `PES_DLY_RST});
        chk(32'(hresp), 0);
        bus(1, 12'h100, 32'hffff_ffff);
        bus(0, 12'h100, 0);
        chk(v, 0);
        bus(1, `PES_PDT_DLY_OFS, 32'h4);
        bus(1, `PES_WDG_DLY_OFS, 32'h2);
        bus(1, `PES_CTRL_OFS, 32'h6);
        bus(1, `PES_RESP_OFS, 32'ha0);
        wdg_trip <= 1'b1;
        cyc(30);
        chk(32'(outs), 0);
        wake <= 1'b1;
        cyc(30);
        chk(32'(outs), 0);
        cyc(40);
        chk(32'(outs), 32'h30);
        wdg_trip <= 1'b0;
        cyc(20);
        wdg_trip <= 1'b1;
        cyc(4);
        chk(32'(outs), 0);
        cyc(20);
        chk(32'(outs), 32'h30);
        wdg_trip <= 1'b0;
        cyc(20);
        for (int i = 0; i < 11; i++) begin
            if (i == 6) bus(1, `PES_CTRL_OFS, 32'h7);
            ev_run(i);
        end
        bus(1, `PES_CTRL_OFS, 32'h6);
        bus(1, `PES_RESP_OFS, 32'h000d_3000);
        bus(1, `PES_IRQ_STAT_OFS, 32'hffff_ffff);
        int_fan_fail <= 1'b1;
        cyc(20);
        chk(32'({outs, irq}), 0);
        main_fan_fail <= 1'b1;
        cyc(20);
        chk(32'({outs, irq}), 32'h80);
        bus(0, `PES_IRQ_STAT_OFS, 0);
        chk(v & 32'h8, 32'h8);
        bus(1, `PES_IRQ_MASK_OFS, 32'h8);
        cyc(3);
        chk(32'(irq), 1);
        bus(1, `PES_IRQ_STAT_OFS, 32'h8);
        cyc(3);
        chk(32'(irq), 0);
        main_fan_fail <= 1'b0;
        int_fan_fail <= 1'b0;
        foreach (lim[k]) begin
            thr = 16'h0100 + 16'({$random(seed)} % 32'h3e00);
            val = thr + 16'(lim[k][9:8] == 2'd1) - 16'(lim[k][9:8] == 2'd2);
            bus(1, `PES_CTRL_OFS, {29'h0, lim[k][7], 2'b10});
            bus(1, `PES_LIM_CFG_OFS, {thr, 10'h0, lim[k][13:10], lim[k][15:14]});
            meas <= 64'(val) << (16 * (3 - lim[k][15:14]));
            cyc(20);
            chk(32'(outs), 32'(lim[k][6:0]));
            meas <= 64'(thr) << (16 * (3 - lim[k][15:14]));
            cyc(10);
            chk(32'(outs), 0);
            bus(1, `PES_LIM_CFG_OFS, 0);
            meas <= '0;
        end
        stop_test();
    end
endmodule
